// ==== design/aps_pkg.sv ====
// Constants and carrier types for the amplifier protection supervisor.
// ====================================================================
// How it works
// - Power-up self-diagnosis; a failure enters error.
// - Power-up lights every lamp for about one second.
// - Program checksum mismatch refuses all operation.
// - An invalid key sets the error state.
// - Overload lights overload lamp, blocks output on.
// - Overload for 10 s: output off, key lamp blinks.
// - Output key press stops its lamp blinking.
// - Overload for 60 s: disable mode, overload lamp blinks.
// - Disable mode refuses all; only power-off leaves it.
// - Over-temperature lights overload lamp, blocks output on.
// - Over-temperature for 10 s: output off, key lamp blinks.
// - Over-temperature for 60 s: disable mode, overload blinks.
// - Overvoltage lights overload lamp, blocks output on.
// - Overvoltage cuts output at once, key lamp blinks.
// - Supply undervoltage or overload is a supply fault.
// - Supply fault blinks lamps, disables all operation.
// - Keys are ignored while the overload lamp blinks.
package aps_pkg;
    // ================================================================
    // Timing.
    localparam int CLK_HZ            = 10_000_000;
    localparam int LAMP_TEST_MS      = 1000;
    localparam int PERSIST_SHORT_S   = 10;
    localparam int PERSIST_LONG_S    = 60;
    localparam int BLINK_HALF_MS     = 250;
    localparam int LAMP_TEST_CYC     = CLK_HZ / 1000 * LAMP_TEST_MS;
    localparam int PERSIST_SHORT_CYC = CLK_HZ * PERSIST_SHORT_S;
    localparam int PERSIST_LONG_CYC  = CLK_HZ * PERSIST_LONG_S;
    localparam int BLINK_HALF_CYC    = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int CNT_W             = 30;
    // ================================================================
    // Register map, byte addresses on APB.
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL     = 12'h000;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 12'h004;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 12'h008;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 12'h00c;
    localparam logic [ADDR_W-1:0] REG_DIAG     = 12'h010;
    localparam int CTRL_OUT_ON  = 0;
    localparam int CTRL_OUT_OFF = 1;
    localparam int CTRL_ERR_CLR = 2;
    localparam int IRQ_DIAG     = 0;
    localparam int IRQ_BADKEY   = 1;
    localparam int IRQ_FORCED   = 2;
    localparam int IRQ_DISABLE  = 3;
    localparam int IRQ_SUPPLY   = 4;
    localparam int IRQ_W        = 5;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
    // ================================================================
    // Carriers.
    typedef struct packed {
        logic overload;
        logic overtemp;
        logic overvolt;
        logic supply_uv;
        logic supply_ovl;
    } aps_faults_t;
    typedef struct packed {
        logic invalid;
        logic out_key;
    } aps_keys_t;
    typedef struct packed {
        logic out_key;
        logic meter_zero;
        logic overload;
        logic error;
    } aps_lamps_t;
    typedef enum logic [2:0] {
        ST_DIAG    = 3'h0,
        ST_RUN     = 3'h1,
        ST_DISABLE = 3'h3,
        ST_SUPPLY  = 3'h2,
        ST_ROMFAIL = 3'h6
    } aps_state_t;
    typedef enum logic [2:0] {
        R_CTRL, R_STATUS, R_IRQ_STAT, R_IRQ_MASK, R_DIAG, R_NONE
    } aps_reg_t;
endpackage

// ==== design/aps_blink.sv ====
// Blink phase generator for the front-panel lamps.
`timescale 1ns/1ps
module aps_blink #(
    parameter int unsigned HALF_CYC = aps_pkg::BLINK_HALF_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      phase
);
    typedef struct packed {
        logic [aps_pkg::CNT_W-1:0] cnt;
        logic                      phase;
    } aps_blink_st_t;
    aps_blink_st_t s_q, s_d;
    logic          tick;

    // ================================================================
    // The divider makes a one-cycle enable; the phase flips on it.
    assign tick = (s_q.cnt == aps_pkg::CNT_W'(HALF_CYC - 1));
    always_comb begin
        s_d     = s_q;
        s_d.cnt = tick ? '0 : s_q.cnt + 1'b1;
        if (tick) begin
            s_d.phase = ~s_q.phase;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign phase = s_q.phase;
endmodule // aps_blink

// ==== design/aps_persist.sv ====
// Persistence timer: pulses when a fault has held for two set lengths.
`timescale 1ns/1ps
module aps_persist #(
    parameter int unsigned SHORT_CYC = aps_pkg::PERSIST_SHORT_CYC,
    parameter int unsigned LONG_CYC  = aps_pkg::PERSIST_LONG_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic cond,
    output logic      hit_short,
    output logic      hit_long
);
    typedef struct packed {
        logic [aps_pkg::CNT_W-1:0] cnt;
        logic                      hit_short;
        logic                      hit_long;
    } aps_persist_st_t;
    aps_persist_st_t s_q, s_d;

    // ================================================================
    // A drop of the condition restarts the count; the count stops at the
    // long limit so that each limit pulses once per episode.
    always_comb begin
        s_d = s_q;
        if (!cond) begin
            s_d.cnt = '0;
        end else if (s_q.cnt != aps_pkg::CNT_W'(LONG_CYC)) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
        s_d.hit_short = cond &&
            (s_q.cnt == aps_pkg::CNT_W'(SHORT_CYC - 1));
        s_d.hit_long  = cond &&
            (s_q.cnt == aps_pkg::CNT_W'(LONG_CYC - 1));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign hit_short = s_q.hit_short;
    assign hit_long  = s_q.hit_long;
endmodule // aps_persist

// ==== design/aps_supervisor.sv ====
// Top of the amplifier protection supervisor with its APB registers.
`timescale 1ns/1ps
module aps_supervisor #(
    parameter int unsigned LAMP_CYC    = aps_pkg::LAMP_TEST_CYC,
    parameter int unsigned SHORT_CYC   = aps_pkg::PERSIST_SHORT_CYC,
    parameter int unsigned LONG_CYC    = aps_pkg::PERSIST_LONG_CYC,
    parameter int unsigned BLINK_CYC   = aps_pkg::BLINK_HALF_CYC,
    parameter int          N_LAMPS     = 9,
    parameter int          ROM_AW      = 8,
    parameter int          ROM_DW      = 16,
    parameter logic [ROM_DW-1:0] ROM_SUM = 16'h0000
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [aps_pkg::ADDR_W-1:0] paddr,
    input  wire logic [aps_pkg::DATA_W-1:0] pwdata,
    output logic      [aps_pkg::DATA_W-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire aps_pkg::aps_faults_t       fault_pins,
    input  wire aps_pkg::aps_keys_t         key_pins,
    output logic      [ROM_AW-1:0]          rom_addr,
    input  wire logic [ROM_DW-1:0]          rom_data,
    input  wire logic [N_LAMPS-1:0]         key_lamp_req,
    input  wire logic                       meter_zero_req,
    output logic      [N_LAMPS-1:0]         key_lamps,
    output aps_pkg::aps_lamps_t             lamps,
    output logic                            output_enable,
    output logic                            irq
);
    // ================================================================
    // State record.
    typedef struct packed {
        aps_pkg::aps_state_t       state;
        aps_pkg::aps_faults_t      flt_s1, flt_s2;
        aps_pkg::aps_keys_t        key_s1, key_s2, key_s3;
        logic [aps_pkg::CNT_W-1:0] diag_cnt;
        logic [ROM_AW:0]           rom_cnt;
        logic                      rom_vld;
        logic [ROM_DW-1:0]         rom_sum;
        logic                      out_on, out_blink, err;
        logic [aps_pkg::IRQ_W-1:0] irq_stat;
        logic [aps_pkg::IRQ_W-1:0] irq_mask;
        aps_pkg::aps_lamps_t       lamps;
        logic [N_LAMPS-1:0]        key_lamps;
        logic                      irq, pready, pslverr;
        logic [aps_pkg::DATA_W-1:0] prdata;
    } aps_st_t;

    localparam logic [ROM_AW:0] ROM_WORDS = {1'b1, {ROM_AW{1'b0}}};

    aps_st_t                   s_q, s_d;
    aps_pkg::aps_faults_t      flt;
    logic                      supply_flt, any_ovl, run, kpress, kbad;
    logic                      blink, h10_ovl, h60_ovl, h10_tmp, h60_tmp;
    logic                      rom_issue, rom_done, acc, wr, wctl;
    aps_pkg::aps_reg_t         sel;
    logic                      sw_on, sw_off, sw_clr;
    logic [aps_pkg::IRQ_W-1:0] ev;
    logic [aps_pkg::IRQ_W-1:0] w1c;

    // ================================================================
    // Address decode for reads and writes.
    function automatic aps_pkg::aps_reg_t reg_of(
        input logic [aps_pkg::ADDR_W-1:0] a);
        unique case (a)
            aps_pkg::REG_CTRL:     reg_of = aps_pkg::R_CTRL;
            aps_pkg::REG_STATUS:   reg_of = aps_pkg::R_STATUS;
            aps_pkg::REG_IRQ_STAT: reg_of = aps_pkg::R_IRQ_STAT;
            aps_pkg::REG_IRQ_MASK: reg_of = aps_pkg::R_IRQ_MASK;
            aps_pkg::REG_DIAG:     reg_of = aps_pkg::R_DIAG;
            default:               reg_of = aps_pkg::R_NONE;
        endcase
    endfunction

    // ================================================================
    // Timers and blink source.
    aps_persist #(
        .SHORT_CYC (SHORT_CYC),
        .LONG_CYC  (LONG_CYC)
    ) u_ovl_timer (
        .pclk      (pclk),
        .presetn   (presetn),
        .cond      (run && flt.overload),
        .hit_short (h10_ovl),
        .hit_long  (h60_ovl)
    );
    aps_persist #(
        .SHORT_CYC (SHORT_CYC),
        .LONG_CYC  (LONG_CYC)
    ) u_tmp_timer (
        .pclk      (pclk),
        .presetn   (presetn),
        .cond      (run && flt.overtemp),
        .hit_short (h10_tmp),
        .hit_long  (h60_tmp)
    );
    aps_blink #(
        .HALF_CYC (BLINK_CYC)
    ) u_blink (
        .pclk    (pclk),
        .presetn (presetn),
        .phase   (blink)
    );

    // ================================================================
    // Decoded conditions; pins are read after the second flop.
    assign flt        = s_q.flt_s2;
    assign supply_flt = flt.supply_uv | flt.supply_ovl;
    assign any_ovl    = flt.overload | flt.overtemp | flt.overvolt;
    assign run        = (s_q.state == aps_pkg::ST_RUN);
    assign kpress     = s_q.key_s2.out_key & ~s_q.key_s3.out_key;
    assign kbad       = s_q.key_s2.invalid & ~s_q.key_s3.invalid;
    assign rom_issue  = (s_q.rom_cnt != ROM_WORDS);
    assign rom_done   = !rom_issue && !s_q.rom_vld;
    // One wait state; a write lands where pready is seen high.
    assign acc        = psel && penable;
    assign wr         = acc && s_q.pready && pwrite;
    assign sel        = reg_of(paddr);
    assign wctl   = wr && sel == aps_pkg::R_CTRL;
    assign sw_on  = wctl && pwdata[aps_pkg::CTRL_OUT_ON];
    assign sw_off = wctl && pwdata[aps_pkg::CTRL_OUT_OFF];
    assign sw_clr = wctl && pwdata[aps_pkg::CTRL_ERR_CLR];
    assign w1c    = (wr && sel == aps_pkg::R_IRQ_STAT) ?
                    pwdata[aps_pkg::IRQ_W-1:0] : '0;

    // ================================================================
    // Next-state logic for the whole supervisor.
    always_comb begin
        s_d        = s_q;
        ev         = '0;
        s_d.flt_s1 = fault_pins;
        s_d.flt_s2 = s_q.flt_s1;
        s_d.key_s1 = key_pins;
        s_d.key_s2 = s_q.key_s1;
        s_d.key_s3 = s_q.key_s2;

        // Checksum walk: address now, data added one cycle later.
        s_d.rom_vld = rom_issue;
        if (rom_issue) begin
            s_d.rom_cnt = s_q.rom_cnt + 1'b1;
        end
        if (s_q.rom_vld) begin
            s_d.rom_sum = s_q.rom_sum + rom_data;
        end

        unique case (s_q.state)
            aps_pkg::ST_DIAG: begin
                // Full lamp test even if the sum is ready.
                if (s_q.diag_cnt != aps_pkg::CNT_W'(LAMP_CYC - 1)) begin
                    s_d.diag_cnt = s_q.diag_cnt + 1'b1;
                end else if (rom_done) begin
                    if (s_q.rom_sum != ROM_SUM) begin
                        s_d.state = aps_pkg::ST_ROMFAIL;
                        s_d.err   = 1'b1;
                        ev[aps_pkg::IRQ_DIAG] = 1'b1;
                    end else begin
                        s_d.state = aps_pkg::ST_RUN;
                    end
                end
            end
            aps_pkg::ST_RUN: begin
                if (supply_flt) begin
                    s_d.state  = aps_pkg::ST_SUPPLY;
                    s_d.out_on = 1'b0;
                    ev[aps_pkg::IRQ_SUPPLY] = 1'b1;
                end else if (h60_ovl || h60_tmp) begin
                    s_d.state  = aps_pkg::ST_DISABLE;
                    s_d.out_on = 1'b0;
                    ev[aps_pkg::IRQ_DISABLE] = 1'b1;
                end else if (h10_ovl || h10_tmp) begin
                    s_d.out_on    = 1'b0;
                    s_d.out_blink = 1'b1;
                    ev[aps_pkg::IRQ_FORCED] = 1'b1;
                end else if (flt.overvolt && s_q.out_on) begin
                    s_d.out_on    = 1'b0;
                    s_d.out_blink = 1'b1;
                    ev[aps_pkg::IRQ_FORCED] = 1'b1;
                end else if (kpress) begin
                    if (s_q.out_blink) begin
                        s_d.out_blink = 1'b0;
                    end else if (s_q.out_on) begin
                        s_d.out_on = 1'b0;
                    end else if (!any_ovl) begin
                        // On request dropped in a fault.
                        s_d.out_on = 1'b1;
                    end
                end else if (sw_off) begin
                    s_d.out_on = 1'b0;
                end else if (sw_on && !any_ovl) begin
                    s_d.out_on = 1'b1;
                end
                if (sw_clr) begin
                    s_d.err = 1'b0;
                end
                // A bad key wins over a clear.
                if (kbad) begin
                    s_d.err = 1'b1;
                    ev[aps_pkg::IRQ_BADKEY] = 1'b1;
                end
            end
            aps_pkg::ST_DISABLE, aps_pkg::ST_SUPPLY,
            aps_pkg::ST_ROMFAIL: begin
                // Terminal: keys and commands are ignored.
                s_d.out_on = 1'b0;
            end
            default: begin
                s_d.state  = aps_pkg::ST_DIAG;
                s_d.out_on = 1'b0;
            end
        endcase

        // Lamp drive follows the state being entered.
        s_d.key_lamps = key_lamp_req;
        s_d.lamps.meter_zero = meter_zero_req;
        s_d.lamps.out_key    = s_d.out_blink ? blink : s_d.out_on;
        s_d.lamps.overload   = any_ovl;
        s_d.lamps.error      = s_d.err;
        unique case (s_d.state)
            aps_pkg::ST_DIAG: begin
                s_d.lamps     = '1;
                s_d.key_lamps = '1;
            end
            aps_pkg::ST_DISABLE: begin
                s_d.lamps.out_key  = 1'b0;
                s_d.lamps.overload = blink;
            end
            aps_pkg::ST_SUPPLY: begin
                s_d.lamps     = {$bits(aps_pkg::aps_lamps_t){blink}};
                s_d.key_lamps = {N_LAMPS{blink}};
            end
            aps_pkg::ST_ROMFAIL: begin
                s_d.lamps       = '0;
                s_d.lamps.error = 1'b1;
                s_d.key_lamps   = '0;
            end
            default: ;
        endcase

        // Sticky events; a set wins over a same-cycle clear.
        s_d.irq_stat = (s_q.irq_stat & ~w1c) | ev;
        if (wr && sel == aps_pkg::R_IRQ_MASK) begin
            s_d.irq_mask = pwdata[aps_pkg::IRQ_W-1:0];
        end
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

        // APB answer, prepared in the first access cycle.
        s_d.pready  = acc && !s_q.pready;
        s_d.pslverr = 1'b0;
        s_d.prdata  = '0;
        if (acc && !s_q.pready) begin
            s_d.pslverr = (sel == aps_pkg::R_NONE);
            unique case (sel)
                aps_pkg::R_STATUS: s_d.prdata[11:0] =
                    {s_q.state, supply_flt, s_q.err, s_q.out_blink,
                     s_q.out_on, flt};
                aps_pkg::R_IRQ_STAT:
                    s_d.prdata[aps_pkg::IRQ_W-1:0] = s_q.irq_stat;
                aps_pkg::R_IRQ_MASK:
                    s_d.prdata[aps_pkg::IRQ_W-1:0] = s_q.irq_mask;
                aps_pkg::R_DIAG: s_d.prdata[ROM_DW-1:0] = s_q.rom_sum;
                default: s_d.prdata = '0;
            endcase
        end
    end

    // ================================================================
    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q          <= '0;
            s_q.state    <= aps_pkg::ST_DIAG;
            s_q.irq_mask <= aps_pkg::IRQ_MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ================================================================
    // Outputs straight from the state record.
    assign prdata        = s_q.prdata;
    assign pready        = s_q.pready;
    assign pslverr       = s_q.pslverr;
    assign rom_addr      = s_q.rom_cnt[ROM_AW-1:0];
    assign key_lamps     = s_q.key_lamps;
    assign lamps         = s_q.lamps;
    assign output_enable = s_q.out_on;
    assign irq           = s_q.irq;
endmodule // aps_supervisor

// ==== tb/aps_panel_model.sv ====
// Program memory model that stands beside the supervisor.
`timescale 1ns/1ps
module aps_panel_model #(
    parameter int AW = 3
) (
    input  wire logic          pclk,
    input  wire logic [AW-1:0] rom_addr,
    input  wire logic          bad,
    output logic      [15:0]   rom_data
);
    // ================================================================
    // Word k holds (k+1)*0x0101; bad flips one bit so the sum must fail.
    always_ff @(posedge pclk) begin
        rom_data <= ((16'(rom_addr) + 16'h0001) * 16'h0101) ^
                    {15'h0000, bad && rom_addr == '0};
    end
endmodule // aps_panel_model

// ==== tb/aps_sup_asserts.sv ====
// Concurrent checks on the supervisor's ports.
`timescale 1ns/1ps
module aps_sup_asserts #(
    parameter int unsigned SHORT_CYC = aps_pkg::PERSIST_SHORT_CYC,
    parameter int unsigned LONG_CYC  = aps_pkg::PERSIST_LONG_CYC
) (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic [aps_pkg::ADDR_W-1:0] paddr,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire aps_pkg::aps_faults_t       fault_pins,
    input wire logic [8:0]                 key_lamps,
    input wire aps_pkg::aps_lamps_t        lamps,
    input wire logic                       output_enable
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ================================================================
    // Pin-side counters; they lead the synchroniser.
    int unsigned ovl_n_q;
    int unsigned sup_n_q;
    logic        dead_q;
    logic        blk;
    assign blk = fault_pins.overload | fault_pins.overtemp |
                 fault_pins.overvolt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovl_n_q <= 0;
            sup_n_q <= 0;
            dead_q  <= 1'b0;
        end else begin
            ovl_n_q <= fault_pins.overload ? ovl_n_q + 1 : 0;
            sup_n_q <= (fault_pins.supply_uv | fault_pins.supply_ovl) ?
                       sup_n_q + 1 : 0;
            dead_q  <= dead_q || ovl_n_q > LONG_CYC + 4 || sup_n_q > 5;
        end
    end
    // ================================================================
    // Bus and front-panel relations.
    apb_wait_a: assert property ($rose(penable) && psel |=> pready)
        else $error("late pready");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (pready |-> pslverr == (paddr > 12'h010))
        else $error("bad pslverr");
    lamp_test_a: assert property ($rose(presetn) |-> ##2
        (lamps == 4'hf && &key_lamps)[*8])
        else $error("lamp test");
    on_block_a: assert property (
        $rose(output_enable) |->
        !($past(blk, 3) && $past(blk, 4) && $past(blk, 5)))
        else $error("on during fault");
    ovv_cut_a: assert property (fault_pins.overvolt[*5]
        |-> !output_enable)
        else $error("on in overvoltage");
    persist_off_a: assert property (ovl_n_q > SHORT_CYC + 4
        |-> !output_enable)
        else $error("on after overload");
    dead_off_a: assert property (
        dead_q |-> !output_enable)
        else $error("on while latched");
    cover property ($rose(dead_q));
    cover property (pready && pslverr);
    cover property ($fell(output_enable));
endmodule // aps_sup_asserts

bind aps_supervisor aps_sup_asserts #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .fault_pins(fault_pins), .key_lamps(key_lamps), .lamps(lamps),
    .output_enable(output_enable));

// ==== tb/tb_amplifier_protection_supervisor.sv ====
// Self-checking testbench for the amplifier protection supervisor.
`timescale 1ns/1ps
module tb_amplifier_protection_supervisor;
    localparam int unsigned SH = 50;
    localparam int unsigned LG = 200;
    logic                 pclk, presetn, psel, penable, pwrite, pready;
    logic                 pslverr, bad, mzr, oe, irq, e;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, r;
    logic [2:0]           rom_addr;
    logic [15:0]          rom_data;
    logic [8:0]           klr, kl;
    logic [4:0]           mask;
    aps_pkg::aps_faults_t flt;
    aps_pkg::aps_keys_t   key;
    aps_pkg::aps_lamps_t  lamps;
    int                   fail_count, tests_run, seed;
    // Expected program sum.
    function automatic logic [15:0] rsum();
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 1; i <= 8; i++) s = s + 16'(i) * 16'h0101;
        return s;
    endfunction
    always #50 pclk = ~pclk;
    aps_supervisor #(.LAMP_CYC(20), .SHORT_CYC(SH), .LONG_CYC(LG),
        .BLINK_CYC(4), .ROM_AW(3), .ROM_SUM(rsum())) DUT (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fault_pins(flt), .key_pins(key),
        .rom_addr(rom_addr), .rom_data(rom_data), .key_lamp_req(klr),
        .meter_zero_req(mzr), .key_lamps(kl), .lamps(lamps),
        .output_enable(oe), .irq(irq));
    aps_panel_model #(.AW(3)) u_panel (.pclk(pclk), .rom_addr(rom_addr),
        .bad(bad), .rom_data(rom_data));
    // ================================================================
    // Reporting, bus and panel tasks.
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s", $time, m);
        end
    endtask
    // Holds the request until pready, then idles a cycle.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            finish_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic press(input logic [1:0] k);
        key <= k;
        repeat (3) @(posedge pclk);
        key <= 2'b00;
        repeat (6) @(posedge pclk);
    endtask
    task automatic wst(input logic [2:0] s, input string m);
        for (int n = 0; n < 40; n++) begin
            apb(1'b0, aps_pkg::REG_STATUS, 32'h0, r);
            if (r[11:9] == s) break;
        end
        chk(r[11:9], s, m);
    endtask
    task automatic rst(input logic b);
        presetn <= 1'b0;
        bad <= b;
        flt <= '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({kl, lamps}, {9'h1ff, 4'hf}, "lamp test");
    endtask
    // Hang guard.
    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        finish_test();
    end
    // ================================================================
    // Main sequence.
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {flt, key, bad} = '0;
        seed = 1;
        klr = 9'($random(seed));
        mzr = 1'($random(seed));
        @(posedge pclk);
        rst(1'b0);
        wst(aps_pkg::ST_RUN, "diag pass");
        apb(1'b0, aps_pkg::REG_DIAG, 32'h0, r);
        chk(r, {16'h0, rsum()}, "rom sum");
        apb(1'b0, aps_pkg::REG_IRQ_MASK, 32'h0, r);
        chk(r, 32'h0, "mask reset");
        apb(1'b0, 12'h0f0, 32'h0, r);
        chk(e, 1'b1, "unmapped");
        mask = 5'($random(seed));
        apb(1'b1, aps_pkg::REG_IRQ_MASK, {27'h0, mask}, r);
        apb(1'b0, aps_pkg::REG_IRQ_MASK, 32'h0, r);
        chk(r, {27'h0, mask}, "mask rw");
        $display("test registers finished");
        press(2'b10);
        apb(1'b0, aps_pkg::REG_STATUS, 32'h0, r);
        chk(r[7], 1'b1, "bad key err");
        apb(1'b0, aps_pkg::REG_IRQ_STAT, 32'h0, r);
        chk(r, 32'h2, "bad key irq");
        chk(irq, mask[1], "irq level");
        apb(1'b1, aps_pkg::REG_IRQ_STAT, 32'h2, r);
        apb(1'b1, aps_pkg::REG_CTRL, 32'h4, r);
        chk(irq, 1'b0, "irq clr");
        apb(1'b1, aps_pkg::REG_IRQ_MASK, 32'h1f, r);
        apb(1'b1, aps_pkg::REG_CTRL, 32'h1, r);
        chk(oe, 1'b1, "on");
        $display("test keys finished");
        flt.overvolt <= 1'b1;
        repeat (6) @(posedge pclk);
        chk({oe, lamps.overload, irq}, 3'b011, "ovv cut");
        press(2'b01);
        apb(1'b0, aps_pkg::REG_STATUS, 32'h0, r);
        chk(r[6], 1'b0, "blink stop");
        press(2'b01);
        chk(oe, 1'b0, "ovv refuse");
        flt <= '0;
        apb(1'b1, aps_pkg::REG_CTRL, 32'h1, r);
        repeat (2) begin
            flt.overtemp <= 1'b1;
            repeat (SH - 15) @(posedge pclk);
            flt <= '0;
            repeat (6) @(posedge pclk);
        end
        chk(oe, 1'b1, "restart");
        flt.overtemp <= 1'b1;
        repeat (SH + 8) @(posedge pclk);
        apb(1'b0, aps_pkg::REG_STATUS, 32'h0, r);
        chk({oe, r[6]}, 2'b01, "tmp cut");
        flt.overload <= 1'b1;
        repeat (LG) @(posedge pclk);
        wst(aps_pkg::ST_DISABLE, "disable");
        press(2'b01);
        flt <= '0;
        apb(1'b1, aps_pkg::REG_CTRL, 32'h1, r);
        chk(oe, 1'b0, "disable off");
        wst(aps_pkg::ST_DISABLE, "dis held");
        $display("test protection finished");
        rst(1'b0);
        wst(aps_pkg::ST_RUN, "rerun");
        if ($random(seed) & 1) flt.supply_uv <= 1'b1;
        else flt.supply_ovl <= 1'b1;
        wst(aps_pkg::ST_SUPPLY, "supply");
        flt <= '0;
        apb(1'b1, aps_pkg::REG_CTRL, 32'h1, r);
        chk(oe, 1'b0, "sup refuse");
        wst(aps_pkg::ST_SUPPLY, "sup held");
        rst(1'b1);
        wst(aps_pkg::ST_ROMFAIL, "rom fail");
        apb(1'b1, aps_pkg::REG_CTRL, 32'h1, r);
        chk(oe, 1'b0, "rom refuse");
        $display("test latched states finished");
        finish_test();
    end
endmodule // tb_amplifier_protection_supervisor
